// *** cdc_pkg.sv ***
// shared constants for the codec direct configuration and continuous transfer block
package cdc_pkg;
  // serial word layout
  localparam int WORD_W      = 16;
  localparam int BIT_CNT_W   = 4;
  localparam int DEV_MSB     = 14;
  localparam int DEV_LSB     = 12;
  localparam int REG_MSB     = 11;
  localparam int REG_LSB     = 9;
  localparam int VAL_MSB     = 7;
  localparam int VAL_LSB     = 0;
  localparam int ADDR3_W     = 3;
  localparam int VAL_W       = 8;
  localparam int NUM_REGS    = 8;
  localparam logic [BIT_CNT_W-1:0] LAST_DATA_BITS = 4'hF; // bits after start bit
  localparam logic [BIT_CNT_W-1:0] CNT_ZERO       = 4'h0;
  localparam logic [BIT_CNT_W-1:0] CNT_ONE        = 4'h1;

  // control register holding the continuous transfer enable
  localparam logic [ADDR3_W-1:0] CTRL3_IDX     = 3'h3;
  localparam int                 CONT_EN_BIT   = 5;
  localparam logic [ADDR3_W-1:0] PSEUDO_IDX    = 3'h0;

  // master/slave mode encoding that allows continuous transfer
  localparam logic [1:0] MODE_FS_PULSE = 2'h0;

  // software port map
  localparam int                 BUS_ADDR_W  = 4;
  localparam logic [BUS_ADDR_W-1:0] STATUS_ADDR = 4'h8;
  localparam logic [BUS_ADDR_W-1:0] LASTW_HI    = 4'h9;
  localparam logic [BUS_ADDR_W-1:0] LASTW_LO    = 4'hA;
  localparam int ST_CONT_ACT  = 0;
  localparam int ST_UNDERRUN  = 1;
  localparam int ST_FRAME_ERR = 2;
  localparam int ST_ADDR_MISS = 3;
  localparam int ST_RX_BUSY   = 4;

  localparam logic [VAL_W-1:0]  CTRL_RESET = 8'h00;
  localparam logic [WORD_W-1:0] ZERO_WORD  = 16'h0000;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_STOP = 2'b10
  } cdc_rx_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_DATA = 2'b10,
    TX_GAP  = 2'b11
  } cdc_tx_e;
endpackage

// *** cdc_core.sv ***
// direct configuration receiver, control registers and continuous data transmitter
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps

module cdc_core
  import cdc_pkg::*;
#(
  parameter int                  DEPTH    = 2,
  parameter int                  GAP_BITS = 2,
  parameter logic [VAL_W*NUM_REGS-1:0] REG_INIT = '0
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  SCLK,
  input  wire logic                  CONFIG_SERIAL_IN,
  input  wire logic [ADDR3_W-1:0]    CASCADE_ADDR,
  input  wire logic [1:0]            MASTER_SLAVE_MODE_SELECT,
  input  wire logic [WORD_W-1:0]     ADC_DATA,
  input  wire logic                  ADC_VALID,
  output logic                       ADC_READY,
  output logic                       DOUT,
  output logic                       FRAME_SYNC_PULSE,
  output logic                       CONT_MODE_ACTIVE,
  output logic [VAL_W*NUM_REGS-1:0]  CTRL_REGS,
  input  wire logic [BUS_ADDR_W-1:0] ADDR,
  input  wire logic [VAL_W-1:0]      WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [VAL_W-1:0]           RDATA
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int GAP_W = (GAP_BITS > 1) ? $clog2(GAP_BITS + 1) : 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(GAP_BITS);

  // three-stage synchronisers for the bit clock and config input
  logic [2:0] sclk_sy_q;
  logic [2:0] cfg_sy_q;
  logic       sclk_st_q;
  logic       cfg_st_q;
  logic       sclk_fall;
  logic       sclk_rise;

  always_ff @(posedge CLK) begin
    if (RST) begin
      sclk_sy_q <= 3'h0;
      cfg_sy_q  <= 3'h7;
    end else begin
      sclk_sy_q <= {sclk_sy_q[1:0], SCLK};
      cfg_sy_q  <= {cfg_sy_q[1:0], CONFIG_SERIAL_IN};
    end
  end

  // a level counts only once stages two and three agree, which filters single-cycle glitches
  always_ff @(posedge CLK) begin
    if (RST) begin
      sclk_st_q <= 1'b0;
      cfg_st_q  <= 1'b1;
    end else begin
      if (sclk_sy_q[1] == sclk_sy_q[2]) sclk_st_q <= sclk_sy_q[2];
      if (cfg_sy_q[1] == cfg_sy_q[2])   cfg_st_q  <= cfg_sy_q[2];
    end
  end

  assign sclk_fall = sclk_st_q & ~sclk_sy_q[2] & (sclk_sy_q[1] == sclk_sy_q[2]);
  assign sclk_rise = ~sclk_st_q & sclk_sy_q[2] & (sclk_sy_q[1] == sclk_sy_q[2]);

  // straps pass the same three stages; a new value counts once stages two and three agree
  logic [2:0][ADDR3_W-1:0] cas_sy_q;
  logic [2:0][1:0]         mode_sy_q;
  logic [ADDR3_W-1:0]      own_addr_q;
  logic [1:0]              mode_st_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cas_sy_q  <= '0;
      mode_sy_q <= '0;
    end else begin
      cas_sy_q  <= {cas_sy_q[1:0], CASCADE_ADDR};
      mode_sy_q <= {mode_sy_q[1:0], MASTER_SLAVE_MODE_SELECT};
    end
  end

  // a bouncing mode pin keeps the old mode, so a switch shows about five clocks late
  always_ff @(posedge CLK) begin
    if (RST) begin
      own_addr_q <= '0;
      mode_st_q  <= MODE_FS_PULSE;
    end else begin
      if (cas_sy_q[1] == cas_sy_q[2])   own_addr_q <= cas_sy_q[2];
      if (mode_sy_q[1] == mode_sy_q[2]) mode_st_q  <= mode_sy_q[2];
    end
  end

  // ---------------- config receiver ----------------
  cdc_rx_e              rx_state_q;
  logic [BIT_CNT_W-1:0] rx_cnt_q;
  logic [WORD_W-1:0]    rx_word_q;
  logic [WORD_W-1:0]    last_word_q;
  logic                 rx_start;
  logic                 rx_last;
  logic                 rx_stop_ok;
  logic                 rx_stop_bad;
  logic                 addr_match;
  logic                 cfg_wr;
  logic [ADDR3_W-1:0]   cfg_idx;
  logic [VAL_W-1:0]     cfg_val;

  assign rx_start    = (rx_state_q == RX_IDLE) & sclk_fall & ~cfg_st_q;
  assign rx_last     = (rx_state_q == RX_DATA) & sclk_fall & (rx_cnt_q == CNT_ONE);
  assign rx_stop_ok  = (rx_state_q == RX_STOP) & sclk_fall & cfg_st_q;
  assign rx_stop_bad = (rx_state_q == RX_STOP) & sclk_fall & ~cfg_st_q;
  assign addr_match  = (rx_word_q[DEV_MSB:DEV_LSB] == own_addr_q);
  assign cfg_wr      = rx_stop_ok & addr_match;
  assign cfg_idx     = rx_word_q[REG_MSB:REG_LSB];
  assign cfg_val     = rx_word_q[VAL_MSB:VAL_LSB];

  // receiver sequencing: start bit, fifteen data bits, stop bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= CNT_ZERO;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (rx_start) begin
            rx_state_q <= RX_DATA;
            rx_cnt_q   <= LAST_DATA_BITS;
          end
        end
        RX_DATA: begin
          if (rx_last) rx_state_q <= RX_STOP;
          if (sclk_fall) rx_cnt_q <= rx_cnt_q - CNT_ONE;
        end
        RX_STOP: begin
          if (sclk_fall) rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // shift MSB first; the start bit enters as bit 15
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_word_q   <= ZERO_WORD;
      last_word_q <= ZERO_WORD;
    end else begin
      if (rx_start) rx_word_q <= {ZERO_WORD[WORD_W-2:0], 1'b0};
      else if ((rx_state_q == RX_DATA) & sclk_fall)
        rx_word_q <= {rx_word_q[WORD_W-2:0], cfg_st_q};
      if (rx_stop_ok) last_word_q <= rx_word_q;
    end
  end

  // ---------------- control registers ----------------
  logic [VAL_W-1:0] ctrl_q [NUM_REGS];
  logic             bus_wr_reg;
  logic [ADDR3_W-1:0] bus_idx;

  assign bus_wr_reg = WR & ~ADDR[BUS_ADDR_W-1];
  assign bus_idx    = ADDR[ADDR3_W-1:0];

  // the serial word wins over a software write in the same cycle; register 0 is a no-op
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_ctrl
      always_ff @(posedge CLK) begin
        if (RST) begin
          ctrl_q[i] <= CTRL_RESET | REG_INIT[i*VAL_W +: VAL_W];
        end else if (i != 0) begin
          if (cfg_wr && cfg_idx == ADDR3_W'(i)) ctrl_q[i] <= cfg_val;
          else if (bus_wr_reg && bus_idx == ADDR3_W'(i)) ctrl_q[i] <= WDATA;
        end
      end
      always_ff @(posedge CLK) begin
        if (RST) CTRL_REGS[i*VAL_W +: VAL_W] <= CTRL_RESET | REG_INIT[i*VAL_W +: VAL_W];
        else     CTRL_REGS[i*VAL_W +: VAL_W] <= ctrl_q[i];
      end
    end
  endgenerate

  logic cont_active;
  assign cont_active = ctrl_q[CTRL3_IDX][CONT_EN_BIT]
                     & (mode_st_q == MODE_FS_PULSE);

  // ---------------- two-entry data buffer ----------------
  logic [WORD_W-1:0] buf_q [DEPTH];
  logic [PTR_W-1:0]  wptr_q;
  logic [PTR_W-1:0]  rptr_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              push;
  logic              pop;
  logic              buf_valid;
  logic [CNT_W-1:0]  cnt_d;
  logic [WORD_W-1:0] buf_head;

  assign push      = ADC_VALID & ADC_READY;
  assign buf_valid = (cnt_q != '0);
  assign buf_head  = buf_q[rptr_q];
  assign cnt_d     = cnt_q + CNT_W'(push) - CNT_W'(pop);

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // ready is registered from the next count, so it is low in every cycle the buffer is full
  always_ff @(posedge CLK) begin
    if (RST) begin
      wptr_q    <= '0;
      rptr_q    <= '0;
      cnt_q     <= '0;
      ADC_READY <= 1'b0;
    end else begin
      if (push) wptr_q <= ptr_inc(wptr_q);
      if (pop)  rptr_q <= ptr_inc(rptr_q);
      cnt_q     <= cnt_d;
      ADC_READY <= (cnt_d != FULL_CNT);
    end
  end

  always_ff @(posedge CLK) begin
    if (push) buf_q[wptr_q] <= ADC_DATA;
  end

  // ---------------- data transmitter ----------------
  cdc_tx_e              tx_state_q;
  logic [BIT_CNT_W-1:0] tx_cnt_q;
  logic [WORD_W-1:0]    tx_sh_q;
  logic [GAP_W-1:0]     gap_q;
  logic                 underrun_set;
  logic                 load_word;
  logic                 word_end;
  logic                 chain;

  assign word_end  = (tx_state_q == TX_DATA) & sclk_rise & (tx_cnt_q == CNT_ZERO);
  assign chain     = word_end & cont_active;
  assign load_word = ((tx_state_q == TX_SYNC) & sclk_rise) | chain;
  assign pop       = load_word & buf_valid;
  assign underrun_set = chain & ~buf_valid;

  // outputs change on the rising bit clock so the partner samples them on the falling one
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_state_q       <= TX_IDLE;
      tx_cnt_q         <= CNT_ZERO;
      tx_sh_q          <= ZERO_WORD;
      gap_q            <= '0;
      DOUT             <= 1'b0;
      FRAME_SYNC_PULSE <= 1'b0;
    end else if (sclk_rise) begin
      case (tx_state_q)
        TX_IDLE: begin
          if (buf_valid) begin
            FRAME_SYNC_PULSE <= 1'b1;
            tx_state_q       <= TX_SYNC;
          end
        end
        TX_SYNC: begin
          FRAME_SYNC_PULSE <= 1'b0;
          tx_sh_q    <= {buf_head[WORD_W-2:0], 1'b0};
          DOUT       <= buf_head[WORD_W-1];
          tx_cnt_q   <= LAST_DATA_BITS;
          tx_state_q <= TX_DATA;
        end
        TX_DATA: begin
          if (tx_cnt_q != CNT_ZERO) begin
            DOUT     <= tx_sh_q[WORD_W-1];
            tx_sh_q  <= {tx_sh_q[WORD_W-2:0], 1'b0};
            tx_cnt_q <= tx_cnt_q - CNT_ONE;
            FRAME_SYNC_PULSE <= cont_active & (tx_cnt_q == CNT_ONE);
          end else if (cont_active) begin
            // next word follows at once; an empty buffer sends a zero word
            FRAME_SYNC_PULSE <= 1'b0;
            tx_sh_q  <= buf_valid ? {buf_head[WORD_W-2:0], 1'b0} : ZERO_WORD;
            DOUT     <= buf_valid & buf_head[WORD_W-1];
            tx_cnt_q <= LAST_DATA_BITS;
          end else begin
            FRAME_SYNC_PULSE <= 1'b0;
            DOUT       <= 1'b0;
            gap_q      <= GAP_LOAD;
            tx_state_q <= TX_GAP;
          end
        end
        TX_GAP: begin
          if (gap_q <= GAP_W'(1)) tx_state_q <= TX_IDLE;
          else gap_q <= gap_q - GAP_W'(1);
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ---------------- status and read port ----------------
  logic underrun_q;
  logic frame_err_q;
  logic addr_miss_q;
  logic st_wr;
  logic [VAL_W-1:0] status_w;
  logic [VAL_W-1:0] rd_mux;

  assign st_wr = WR & (ADDR == STATUS_ADDR);

  // sticky flags clear by writing one; a new event in the same cycle wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      underrun_q  <= 1'b0;
      frame_err_q <= 1'b0;
      addr_miss_q <= 1'b0;
    end else begin
      underrun_q  <= underrun_set | (underrun_q & ~(st_wr & WDATA[ST_UNDERRUN]));
      frame_err_q <= rx_stop_bad | (frame_err_q & ~(st_wr & WDATA[ST_FRAME_ERR]));
      addr_miss_q <= (rx_stop_ok & ~addr_match)
                   | (addr_miss_q & ~(st_wr & WDATA[ST_ADDR_MISS]));
    end
  end

  always_comb begin
    status_w = '0;
    status_w[ST_CONT_ACT]  = cont_active;
    status_w[ST_UNDERRUN]  = underrun_q;
    status_w[ST_FRAME_ERR] = frame_err_q;
    status_w[ST_ADDR_MISS] = addr_miss_q;
    status_w[ST_RX_BUSY]   = (rx_state_q != RX_IDLE);
  end

  assign rd_mux = ~ADDR[BUS_ADDR_W-1]                    ? ctrl_q[bus_idx] :
                  (ADDR == STATUS_ADDR)                   ? status_w :
                  (ADDR == LASTW_HI)                      ? last_word_q[WORD_W-1:VAL_W] :
                  (ADDR == LASTW_LO)                      ? last_word_q[VAL_W-1:0] :
                                                            CTRL_RESET;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA            <= '0;
      CONT_MODE_ACTIVE <= 1'b0;
    end else begin
      RDATA            <= RD ? rd_mux : '0;
      CONT_MODE_ACTIVE <= cont_active;
    end
  end

endmodule

// *** cdc_props.sv ***
// port-level checks of the config and data block
`timescale 1ns/100ps
module cdc_props
  import cdc_pkg::*;
(
  input wire logic                      CLK,
  input wire logic                      RST,
  input wire logic [1:0]                MASTER_SLAVE_MODE_SELECT,
  input wire logic                      FRAME_SYNC_PULSE,
  input wire logic                      CONT_MODE_ACTIVE,
  input wire logic [VAL_W*NUM_REGS-1:0] CTRL_REGS,
  input wire logic [BUS_ADDR_W-1:0]     ADDR,
  input wire logic [VAL_W-1:0]          WDATA,
  input wire logic                      WR,
  input wire logic                      RD,
  input wire logic [VAL_W-1:0]          RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic       fs_q;
  logic       cont_q;
  logic [8:0] gap_q;
  wire        fs_rise  = FRAME_SYNC_PULSE & ~fs_q;
  wire        cont_bit = CTRL_REGS[VAL_W*CTRL3_IDX+CONT_EN_BIT];
  wire        mode_ok  = MASTER_SLAVE_MODE_SELECT == MODE_FS_PULSE;
  wire [8:0]  gap_d    = fs_rise ? 9'h001 : gap_q + {8'h00, gap_q != 9'h1FF};
  // clocks since the last frame pulse rose; saturates so a long idle never wraps
  always_ff @(posedge CLK) begin
    if (RST) begin
      fs_q   <= 1'b0;
      cont_q <= 1'b0;
      gap_q  <= 9'h1FF;
    end else begin
      fs_q   <= FRAME_SYNC_PULSE;
      cont_q <= fs_rise ? CONT_MODE_ACTIVE : cont_q;
      gap_q  <= gap_d;
    end
  end
  chk_rdata_quiet:
    assert property (!$past(RD) |-> RDATA == '0) else $error("read data without a read");
  chk_read_mirror:
    assert property (RD && ADDR inside {[1:7]} |=> RDATA == CTRL_REGS[$past(ADDR)*8 +: 8])
    else $error("read data differs from register");
  chk_write_lands:
    assert property (WR && ADDR inside {[1:7]} |-> ##2
      CTRL_REGS[$past(ADDR, 2)*8 +: 8] == $past(WDATA, 2)) else $error("write lost");
  chk_pseudo_zero:
    assert property (CTRL_REGS[VAL_W-1:0] == '0) else $error("pseudo register written");
  chk_cont_mode:
    assert property (CONT_MODE_ACTIVE |-> $past(MASTER_SLAVE_MODE_SELECT, 4) == MODE_FS_PULSE
      || $past(MASTER_SLAVE_MODE_SELECT, 5) == MODE_FS_PULSE)
    else $error("continuous mode outside pulse mode");
  chk_cont_bit:
    assert property (CONT_MODE_ACTIVE |-> cont_bit || $past(cont_bit))
    else $error("continuous mode without enable bit");
  chk_cont_on:
    assert property ((cont_bit && mode_ok) [*6] |-> CONT_MODE_ACTIVE)
    else $error("continuous mode not entered");
  chk_fs_width:
    assert property ($rose(FRAME_SYNC_PULSE) |-> FRAME_SYNC_PULSE [*8] ##1 !FRAME_SYNC_PULSE)
    else $error("frame pulse not one bit long");
  chk_fs_spacing:
    assert property (fs_rise && cont_q && CONT_MODE_ACTIVE |-> gap_q inside {[127:129]})
    else $error("continuous words not back to back");
  cover property ($rose(CONT_MODE_ACTIVE));
  cover property (fs_rise && cont_q && CONT_MODE_ACTIVE);
  cover property (RD && ADDR == STATUS_ADDR);
endmodule

bind cdc_core cdc_props u_props (.*);

// *** cdc_link_model.sv ***
// far-side model: bit clock, config word sender, data word capture
`timescale 1ns/100ps
module cdc_link_model (
  output logic        sclk,
  output logic        cfg_in,
  input  wire logic   dout,
  input  wire logic   fsync,
  output logic [15:0] rx_word,
  output int          rx_cnt
);
  logic [15:0] sh;
  int          left;
  // free-running bit clock, unrelated in phase, low across reset release
  initial begin
    cfg_in = 1'b1;
    sclk = 1'b0;
    left = 0;
    rx_cnt = 0;
    #337;
    forever #200 sclk = ~sclk;
  end
  // capture on the falling edge; a pulse during the last bit opens the next word
  always @(negedge sclk) begin
    if (left > 0) begin
      sh = {sh[14:0], dout};
      left = left - 1;
      if (left == 0) begin
        rx_word = sh;
        rx_cnt = rx_cnt + 1;
      end
    end
    if (fsync)
      left = 16;
  end
  // bits change on the rising edge so they are settled at the sampling fall
  task automatic send_cfg(input logic [15:0] w, input logic stop);
    for (int i = 15; i >= 0; i--) begin
      @(posedge sclk);
      cfg_in <= w[i];
    end
    @(posedge sclk);
    cfg_in <= stop;
    @(posedge sclk);
    cfg_in <= 1'b1;
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench: register port, config link and data stream
`timescale 1ns/100ps
module tb_top
  import cdc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, cfg_in, ready, dout, fsync, cont;
  logic [2:0]  cas = 3'h0;
  logic [1:0]  mode = 2'h0;
  logic [15:0] adc = 16'h0000;
  logic [15:0] rx_word, exp_w;
  logic        valid = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, full_seen = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [7:0]  exp_reg [8];
  logic [7:0]  rq [$];
  logic [15:0] wq [$];
  int          rx_cnt, failures = 0, cmp_count = 0, cyc = 0;
  integer      seed = 32'hd75b4fe4;

  always #25 clk = ~clk;

  cdc_core DUT (.CLK(clk), .RST(rst), .SCLK(sclk), .CONFIG_SERIAL_IN(cfg_in),
    .CASCADE_ADDR(cas), .MASTER_SLAVE_MODE_SELECT(mode), .ADC_DATA(adc),
    .ADC_VALID(valid), .ADC_READY(ready), .DOUT(dout), .FRAME_SYNC_PULSE(fsync),
    .CONT_MODE_ACTIVE(cont), .CTRL_REGS(), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata));
  cdc_link_model u_link (.sclk(sclk), .cfg_in(cfg_in), .dout(dout), .fsync(fsync),
    .rx_word(rx_word), .rx_cnt(rx_cnt));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, read reply checker and refusal watch
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      failures++;
      conclude();
    end
    if (valid && !ready)
      full_seen = 1'b1;
    rd_d <= rd;
    if (rd_d)
      chk8(rdata, rq.pop_front());
  end
  // a zero word in continuous mode is an underrun filler, not a loss
  always @(rx_cnt) begin
    exp_w = (wq.size() > 0 && !(rx_word == 16'h0000 && cont)) ? wq.pop_front() : 16'h0000;
    chk16(rx_word, exp_w);
  end

  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    if (a inside {[1:7]})
      exp_reg[a[2:0]] = d;
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic cfg(input logic [2:0] dv, input logic [2:0] ri, input logic [7:0] v, input logic s);
    u_link.send_cfg({1'b0, dv, ri, 1'b1, v}, s);
    if (dv == cas && s && ri != 3'h0)
      exp_reg[ri] = v;
    repeat (8) @(posedge clk);
  endtask
  task automatic send_word(input logic [15:0] w);
    int n = 0;
    adc <= w;
    valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!ready && n < 5000);
    wq.push_back(w);
  endtask
  task automatic drain();
    int n = 0;
    valid <= 1'b0;
    while (wq.size() > 0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    repeat (40) @(posedge clk);
  endtask

  initial begin
    for (int i = 0; i < 8; i++)
      exp_reg[i] = 8'h00;
    cas = 3'($random(seed));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // back-to-back writes, read-back, pseudo and unmapped places
    for (int a = 0; a < 8; a++)
      wreg(4'(a), 8'($random(seed)) & (a == 3 ? 8'hDF : 8'hFF));
    for (int a = 0; a < 8; a++)
      rreg(4'(a), exp_reg[a]);
    rreg(4'hC, 8'h00);
    rreg(4'hF, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    $display("done: register port");
    // good word, foreign device address, broken stop bit, then flag clear
    cfg(cas, 3'h2, 8'($random(seed)), 1'b1);
    cfg(cas ^ 3'h1, 3'h2, 8'h5A, 1'b1);
    rreg(4'h2, exp_reg[2]);
    rreg(STATUS_ADDR, 8'h08);
    rreg(LASTW_HI, {1'b0, cas ^ 3'h1, 3'h2, 1'b1});
    rreg(LASTW_LO, 8'h5A);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    cfg(cas, 3'h4, 8'h3C, 1'b0);
    rreg(4'h4, exp_reg[4]);
    rreg(STATUS_ADDR, 8'h0C);
    rreg(LASTW_LO, 8'h5A);
    wreg(STATUS_ADDR, 8'h0C);
    rreg(STATUS_ADDR, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    $display("done: config link");
    // offer faster than the link drains so the buffer refuses
    repeat (6)
      send_word(16'($random(seed)) | 16'h0001);
    drain();
    chk8({7'h00, full_seen}, 8'h01);
    $display("done: normal stream");
    cfg(cas, 3'h3, 8'h20, 1'b1);
    repeat (300) @(posedge clk);
    rreg(STATUS_ADDR, 8'h01);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    repeat (5)
      send_word(16'($random(seed)) | 16'h0001);
    drain();
    mode <= 2'h1;
    repeat (300) @(posedge clk);
    rreg(STATUS_ADDR, 8'h02);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    repeat (4) @(posedge clk);
    $display("done: continuous stream");
    conclude();
  end
endmodule
